// ### testbench/lcd_ctrl_asserts.sv
`timescale 1ns/100ps
module lcd_ctrl_asserts (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rdata,
  input wire logic [1:0] multiplex_select,
  input wire logic half_bias,
  input wire logic static_bias,
  input wire logic frame_tick,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence main_wr;
    wr_stb && addr == lcd_ctrl_pkg::OFS_MAIN;
  endsequence
  sequence phase_wr_rd;
    wr_stb && addr == lcd_ctrl_pkg::OFS_PHASE ##2 rd_stb && addr == lcd_ctrl_pkg::OFS_PHASE;
  endsequence
  AST_STATIC_BIAS: assert property (static_bias == (multiplex_select == 2'h0))
    else $error("static bias wrong");
  AST_HALF_BIAS: assert property (half_bias |-> multiplex_select inside {2'h1, 2'h2})
    else $error("half bias with bad mux");
  AST_MUX_WRITE: assert property (main_wr |=> multiplex_select == $past(wdata[1:0]))
    else $error("mux not taken");
  AST_OFF_MUX: assert property (main_wr ##0 wdata == 8'h00 |=> multiplex_select == 2'h0 && static_bias)
    else $error("off write left mux");
  AST_OFF_QUIET: assert property (main_wr ##0 wdata == 8'h00 |=> ##1 !frame_tick [*8])
    else $error("tick after off");
  AST_TICK_GAP: assert property (frame_tick |=> !frame_tick [*8] ##1 !frame_tick [*7])
    else $error("ticks too close");
  AST_IRQ_MASK: assert property (wr_stb && addr == lcd_ctrl_pkg::OFS_IRQ_MASK && wdata == 8'h00 |=> !irq)
    else $error("masked irq high");
  AST_PHASE_RD: assert property (phase_wr_rd |=> {rdata[7], rdata[3:0]} == $past({wdata[7], wdata[3:0]}, 3))
    else $error("phase readback wrong");
endmodule
bind lcd_phase_prescale_control lcd_ctrl_asserts chk_i (.ref_clk(ref_clk), .arst_n(arst_n), .addr(addr),
  .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .multiplex_select(multiplex_select),
  .half_bias(half_bias), .static_bias(static_bias), .frame_tick(frame_tick), .irq(irq));

// ### testbench/lcd_panel_model.sv
`timescale 1ns/100ps
module lcd_panel_model (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic frame_tick,
  output logic [15:0] period
);
  logic [15:0] cnt_r;
  // glass only sees frames; spacing of ticks is what it can judge
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 16'h0000;
      period <= 16'h0000;
    end else if (frame_tick) begin
      period <= cnt_r + 16'h0001;
      cnt_r <= 16'h0000;
    end else
      cnt_r <= cnt_r + 16'h0001;
  end
endmodule

// ### testbench/lcd_phase_prescale_control_tb.sv
`timescale 1ns/100ps
module lcd_phase_prescale_control_tb;
  logic ref_clk = 0, arst_n = 0, wr_stb = 0, rd_stb = 0, sleep_req = 0, ce = 1, hb, sb, tick, irq, ph;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [23:0] seg;
  logic [1:0] mux, src;
  logic [15:0] per;
  int n_errors = 0, cmp_count = 0;
  initial forever #12.5 ref_clk = ~ref_clk;
  lcd_phase_prescale_control dut (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(ce), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .sleep_req(sleep_req), .segment_pin_enable(seg),
    .multiplex_select(mux), .timing_source(src), .half_bias(hb), .static_bias(sb), .common_phase(ph),
    .frame_tick(tick), .irq(irq));
  lcd_panel_model panel (.ref_clk(ref_clk), .arst_n(arst_n), .frame_tick(tick), .period(per));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic wait_tick;
    int i;
    @(negedge ref_clk);
    for (i = 0; i < 1000 && tick !== 1'b1; i++) @(negedge ref_clk);
    if (i == 1000) begin
      n_errors++;
      tally_and_finish;
    end
    @(posedge ref_clk);
    #1;
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(lcd_ctrl_pkg::OFS_PHASE, 8'h13);
    wr(lcd_ctrl_pkg::OFS_PHASE, 8'hFF);
    rd(lcd_ctrl_pkg::OFS_PHASE, 8'hDF);
    wr(lcd_ctrl_pkg::OFS_PHASE, 8'h01);
    for (int k = 0; k < 3; k++) wr(lcd_ctrl_pkg::OFS_SEG0 + 4'(k), 8'(17 * (k + 1)));
    chk(seg, 24'h332211);
    @(posedge ref_clk) ce <= 1'b0;
    wr(lcd_ctrl_pkg::OFS_SEG0, 8'hAA);
    ce <= 1'b1;
    chk(seg, 24'h332211);
    wr(lcd_ctrl_pkg::OFS_MAIN, 8'h45);
    chk({src, mux, sb}, 5'h0A);
    for (int k = 0; k < 24; k++) begin
      wr(lcd_ctrl_pkg::OFS_PIX_ADDR, 8'(k));
      wr(lcd_ctrl_pkg::OFS_PIX_DATA, 8'(k));
    end
    wr(lcd_ctrl_pkg::OFS_PIX_ADDR, 8'h05);
    rd(lcd_ctrl_pkg::OFS_PIX_DATA, 8'h05);
    wr(lcd_ctrl_pkg::OFS_IRQ_STAT, 8'h03);
    wr(lcd_ctrl_pkg::OFS_IRQ_MASK, 8'h01);
    wr(lcd_ctrl_pkg::OFS_MAIN, 8'hC5);
    rd(lcd_ctrl_pkg::OFS_PHASE, 8'h31);
    wait_tick;
    chk(ph, 1'b1);
    wait_tick;
    chk({per, irq}, {16'h0020, 1'b1});
    wr(lcd_ctrl_pkg::OFS_IRQ_STAT, 8'h01);
    chk(irq, 1'b0);
    @(posedge ref_clk) sleep_req <= 1'b1;
    rd(lcd_ctrl_pkg::OFS_PHASE, 8'h11);
    @(posedge ref_clk) sleep_req <= 1'b0;
    wr(lcd_ctrl_pkg::OFS_PHASE, 8'h41);
    chk(hb, 1'b1);
    wr(lcd_ctrl_pkg::OFS_MAIN, 8'h80);
    chk({hb, sb}, 2'b01);
    rd(lcd_ctrl_pkg::OFS_IRQ_STAT, 8'h02);
    wr(lcd_ctrl_pkg::OFS_MAIN, 8'h00);
    rd(lcd_ctrl_pkg::OFS_PHASE, 8'h51);
    chk(ph, 1'b0);
    rd(4'hF, 8'h00);
    wr(lcd_ctrl_pkg::OFS_IRQ_MASK, 8'h00);
    chk(irq, 1'b0);
    repeat (2) @(posedge ref_clk);
    tally_and_finish;
  end
endmodule

// ### verilog/frame_divider.sv
`timescale 1ns/100ps
module frame_divider (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic run,
  input wire logic [3:0] ratio,
  output logic tick
);
  logic [7:0] base_r, base_nxt;
  logic [3:0] div_r, div_nxt;
  always_comb begin
    base_nxt = base_r;
    div_nxt = div_r;
    tick = 1'b0;
    if (!run) begin
      base_nxt = 8'h00;
      div_nxt = 4'h0;
    end else if (base_r == lcd_ctrl_pkg::FRAME_BASE_CYC) begin
      base_nxt = 8'h00;
      if (div_r >= ratio) begin
        div_nxt = 4'h0;
        tick = 1'b1;
      end else begin
        div_nxt = div_r + 4'h1;
      end
    end else begin
      base_nxt = base_r + 8'h01;
    end
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      base_r <= 8'h00;
      div_r <= 4'h0;
    end else if (clk_en) begin
      base_r <= base_nxt;
      div_r <= div_nxt;
    end
  end
endmodule

// ### verilog/lcd_ctrl_pkg.sv
package lcd_ctrl_pkg;
  localparam logic [3:0] OFS_PHASE = 4'h0;
  localparam logic [3:0] OFS_MAIN = 4'h1;
  localparam logic [3:0] OFS_SEG0 = 4'h2;
  localparam logic [3:0] OFS_SEG1 = 4'h3;
  localparam logic [3:0] OFS_SEG2 = 4'h4;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h5;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h6;
  localparam logic [3:0] OFS_PIX_ADDR = 4'h7;
  localparam logic [3:0] OFS_PIX_DATA = 4'h8;
  localparam int NUM_PIX = 24;
  localparam int BIT_WFT = 7;
  localparam int BIT_BIAS = 6;
  localparam int BIT_ACT = 5;
  localparam int BIT_WA = 4;
  localparam logic [7:0] PHASE_WMASK = 8'hCF;
  localparam logic [7:0] PHASE_RST = 8'h03;
  localparam logic [7:0] MAIN_RST = 8'h00;
  localparam logic [7:0] MAIN_EN_BIT = 8'h80;
  localparam logic [1:0] MUX_STATIC = 2'h0;
  localparam logic [1:0] MUX_QUAD = 2'h3;
  localparam logic [1:0] IRQ_FRAME = 2'h1;
  localparam logic [1:0] IRQ_BIAS_ERR = 2'h2;
  localparam logic [7:0] FRAME_BASE_CYC = 8'h0F;
  typedef struct packed {
    logic waveform_type;
    logic bias;
    logic [3:0] prescale;
  } phase_type;
  typedef struct packed {
    logic en;
    logic sleep_en;
    logic [1:0] src;
    logic [1:0] mux;
  } main_type;
endpackage

// ### verilog/lcd_phase_prescale_control.sv
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/100ps
// Notes on behaviour
// - waveform_type set flips phase every frame (type B), clear flips it within each common period (type A).
// - bias_select is half bias for mux 01/10, third bias otherwise, and must stay 0 for mux 00 and 11.
// - driver_active_status reads 1 while the driver runs and 0 while inactive.
// - pixel_write_allowed reads 1 when pixel data may be written and 0 otherwise.
// - frame_prescale divides the frame clock by its value plus one, 1:1 to 1:16.
// - writing all zeros to the main control register turns the module off.
module lcd_phase_prescale_control (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic sleep_req,
  output logic [23:0] segment_pin_enable,
  output logic [1:0] multiplex_select,
  output logic [1:0] timing_source,
  output logic half_bias,
  output logic static_bias,
  output logic common_phase,
  output logic frame_tick,
  output logic irq
);
  lcd_ctrl_pkg::phase_type phase_r, phase_nxt;
  lcd_ctrl_pkg::main_type main_r, main_nxt;
  logic [23:0] seg_r, seg_nxt;
  logic [7:0] pix_r [lcd_ctrl_pkg::NUM_PIX];
  logic [7:0] pix_nxt [lcd_ctrl_pkg::NUM_PIX];
  logic [4:0] pix_idx_r, pix_idx_nxt;
  logic [1:0] stat_r, stat_nxt;
  logic [1:0] mask_r, mask_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic ph_r, ph_nxt;
  logic [1:0] com_r, com_nxt;
  logic active, write_ok, tick, bias_bad;
  logic [1:0] ev;

  // sleep stops the driver only if sleep_mode_enable is set
  assign active = main_r.en && !(main_r.sleep_en && sleep_req);
  // pixel writes blocked while a type-B frame is mid-phase, avoiding a torn frame
  assign write_ok = !active || !phase_r.waveform_type || !ph_r;
  assign bias_bad = phase_r.bias && (main_r.mux == lcd_ctrl_pkg::MUX_STATIC
                    || main_r.mux == lcd_ctrl_pkg::MUX_QUAD);

  frame_divider u_div (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .run(active),
    .ratio(phase_r.prescale),
    .tick(tick)
  );

  assign ev = {bias_bad && active, tick};

  // configuration group: software-owned fields, changed only by register writes
  always_comb begin
    phase_nxt = phase_r;
    main_nxt = main_r;
    seg_nxt = seg_r;
    pix_idx_nxt = pix_idx_r;
    if (wr_stb) begin
      case (addr)
        lcd_ctrl_pkg::OFS_PHASE: phase_nxt = phase_type_of(wdata & lcd_ctrl_pkg::PHASE_WMASK);
        lcd_ctrl_pkg::OFS_MAIN: main_nxt = main_type_of(wdata);
        lcd_ctrl_pkg::OFS_SEG0: seg_nxt[7:0] = wdata;
        lcd_ctrl_pkg::OFS_SEG1: seg_nxt[15:8] = wdata;
        lcd_ctrl_pkg::OFS_SEG2: seg_nxt[23:16] = wdata;
        lcd_ctrl_pkg::OFS_PIX_ADDR: pix_idx_nxt = wdata[4:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_r <= lcd_ctrl_pkg::phase_type'(lcd_ctrl_pkg::PHASE_RST[5:0]);
      main_r <= lcd_ctrl_pkg::main_type'(lcd_ctrl_pkg::MAIN_RST[5:0]);
      seg_r <= 24'h000000;
      pix_idx_r <= 5'h00;
    end else if (clk_en) begin
      phase_r <= phase_nxt;
      main_r <= main_nxt;
      seg_r <= seg_nxt;
      pix_idx_r <= pix_idx_nxt;
    end
  end

  // interrupt group: an event in the same cycle as its clear wins, so no event is lost
  always_comb begin
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    if (wr_stb && addr == lcd_ctrl_pkg::OFS_IRQ_STAT) begin
      stat_nxt = stat_r & ~wdata[1:0];
    end
    if (wr_stb && addr == lcd_ctrl_pkg::OFS_IRQ_MASK) begin
      mask_nxt = wdata[1:0];
    end
    stat_nxt = stat_nxt | ev;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_r <= 2'h0;
      mask_r <= 2'h0;
    end else if (clk_en) begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
    end
  end

  // readback group: rdata is zero outside the cycle after a read strobe
  always_comb begin
    rdata_nxt = 8'h00;
    if (rd_stb) begin
      case (addr)
        lcd_ctrl_pkg::OFS_PHASE: rdata_nxt = {phase_r.waveform_type, phase_r.bias, active, write_ok, phase_r.prescale};
        lcd_ctrl_pkg::OFS_MAIN: rdata_nxt = {main_r.en, main_r.sleep_en, 2'h0, main_r.src, main_r.mux};
        lcd_ctrl_pkg::OFS_SEG0: rdata_nxt = seg_r[7:0];
        lcd_ctrl_pkg::OFS_SEG1: rdata_nxt = seg_r[15:8];
        lcd_ctrl_pkg::OFS_SEG2: rdata_nxt = seg_r[23:16];
        lcd_ctrl_pkg::OFS_IRQ_STAT: rdata_nxt = {6'h00, stat_r};
        lcd_ctrl_pkg::OFS_IRQ_MASK: rdata_nxt = {6'h00, mask_r};
        lcd_ctrl_pkg::OFS_PIX_ADDR: rdata_nxt = {3'h0, pix_idx_r};
        lcd_ctrl_pkg::OFS_PIX_DATA: rdata_nxt = (pix_idx_r < 5'h18) ? pix_r[pix_idx_r] : 8'h00;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 8'h00;
    end else if (clk_en) begin
      rdata_r <= rdata_nxt;
    end
  end

  function automatic lcd_ctrl_pkg::phase_type phase_type_of(input logic [7:0] v);
    phase_type_of = '{waveform_type: v[lcd_ctrl_pkg::BIT_WFT], bias: v[lcd_ctrl_pkg::BIT_BIAS], prescale: v[3:0]};
  endfunction

  function automatic lcd_ctrl_pkg::main_type main_type_of(input logic [7:0] v);
    main_type_of = '{en: v[7], sleep_en: v[6], src: v[3:2], mux: v[1:0]};
  endfunction

  // phase and common sequencing: type B flips per frame, type A per common slot
  always_comb begin
    ph_nxt = ph_r;
    com_nxt = com_r;
    if (!active) begin
      ph_nxt = 1'b0;
      com_nxt = 2'h0;
    end else if (tick) begin
      com_nxt = (com_r >= main_r.mux) ? 2'h0 : com_r + 2'h1;
      if (phase_r.waveform_type) begin
        if (com_r >= main_r.mux) ph_nxt = !ph_r;
      end else begin
        ph_nxt = !ph_r;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_r <= 1'b0;
      com_r <= 2'h0;
    end else if (clk_en) begin
      ph_r <= ph_nxt;
      com_r <= com_nxt;
    end
  end

  // pixel store: writes dropped while not allowed or past the last entry
  always_comb begin
    for (int i = 0; i < lcd_ctrl_pkg::NUM_PIX; i++) begin
      pix_nxt[i] = pix_r[i];
    end
    if (wr_stb && addr == lcd_ctrl_pkg::OFS_PIX_DATA && write_ok && pix_idx_r < 5'h18) begin
      pix_nxt[pix_idx_r] = wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < lcd_ctrl_pkg::NUM_PIX; i++) begin
        pix_r[i] <= 8'h00;
      end
    end else if (clk_en) begin
      for (int i = 0; i < lcd_ctrl_pkg::NUM_PIX; i++) begin
        pix_r[i] <= pix_nxt[i];
      end
    end
  end

  assign rdata = rdata_r;
  assign segment_pin_enable = seg_r;
  assign multiplex_select = main_r.mux;
  assign timing_source = main_r.src;
  assign half_bias = phase_r.bias && !bias_bad;
  assign static_bias = main_r.mux == lcd_ctrl_pkg::MUX_STATIC;
  assign common_phase = ph_r;
  assign frame_tick = tick;
  assign irq = |(stat_r & mask_r);
endmodule
